/* File: cbm_core_model.sv */
/* core-side data path model: one internal data operation per call.
   assumes the bench supplies core_clk and calls after reset release. */
module cbm_core_model (
  input  wire logic  core_clk,
  output logic       dataReq,
  output logic [2:0] dataOp,
  output logic [7:0] dataAddr,
  output logic       dataIndirect,
  output logic       dataIsBit,
  output logic [7:0] dataWdata,
  output logic [1:0] regBankSel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {dataReq, dataOp, dataAddr, dataIndirect, dataIsBit} = 13'h0;
    {dataWdata, regBankSel} = 10'h0;
  end
  // data is inverted after the taking edge so stale values never match
  task automatic op(input logic [2:0] o, input logic [7:0] a,
    input logic ind, input logic isBit, input logic [7:0] d,
    input logic [1:0] rb);
    {dataOp, dataAddr, dataIndirect, dataIsBit, dataWdata} = {o, a, ind,
      isBit, d};
    regBankSel = rb;
    dataReq = 1'b1;
    @(posedge core_clk);
    #1;
    dataReq = 1'b0;
    dataWdata = ~d;
  endtask
endmodule // cbm_core_model

/* File: cbm_defs.vh */
/*
  constants for the code bank and data memory map block.
  assumes inclusion by bare name from plain verilog design files.
*/
// What this block does
// - bank zero always sits at program addresses 0x0000 to 0x7FFF
// - selected upper bank sits at program addresses 0x8000 to 0xFFFF
// - fetches at 0x8000 and up use fetch bank field bits 1:0
// - fetch bank field changes only from code running in bank zero
// - constant reads and flash writes up high use constant bank bits 5:4
// - reserved bits 7:6 and 3:2 read zero; software writes zeros
// - on 128 kB parts bank three 0xFC00 to 0xFFFF is reserved
// - code reads hit flash; external writes hit expansion RAM or flash
// - 256 bytes internal RAM; lower 128 reached directly or indirectly
// - direct access above 0x7F goes to special function registers
// - indirect access above 0x7F goes to separate upper RAM
// - 0x00 to 0x1F are four register banks chosen by status bits 3,4
// - bank select 00..11 maps registers to 0x00, 0x08, 0x10, 0x18
// - indirect pointers come from registers zero and one of active bank
// - bytes 0x20 to 0x2F form bit addresses 0x00 to 0x7F, 8k+n
// - bit versus byte access chosen by operand type, not address
// - stack pointer marks last used; push writes at pointer+1 then bumps
// - reset loads stack pointer 0x07 so first push lands at 0x08
// - stack spans all 256 bytes and the pointer wraps
`ifndef CBM_DEFS_VH
`define CBM_DEFS_VH
`define CBM_BANK_SEL_ADDR   8'hF5
`define CBM_BANK_SEL_RESET  8'h11
`define CBM_BANK_SEL_MASK   8'h33
`define CBM_FETCH_LSB       0
`define CBM_CONST_LSB       4
`define CBM_UPPER_BIT       15
`define CBM_RESERVED_BASE   16'hFC00
`define CBM_SP_RESET        8'h07
`define CBM_BITREGION_BASE  8'h20
`define CBM_REGBANK_LSB     3
`define CBM_DIRECT_TOP      8'h7F
`endif

/* File: cbm_mem_map.v */
/*
  code bank select register, program space translation and internal data
  memory decode with register banks, bit region and stack pointer.
  assumes the core presents one data operation per cycle on plain
  synchronous inputs; special function register data comes from outside.
*/
`include "cbm_defs.vh"
module cbm_mem_map #(
  parameter BIG_FLASH = 1'b1
) (
  input  wire        core_clk,
  input  wire        nrst,
  // special function register port of the bank select register
  input  wire        sfrWr,
  input  wire [7:0]  sfrAddr,
  input  wire [7:0]  sfrWdata,
  input  wire [15:0] curPc,
  output reg  [7:0]  sfrRdata,
  output reg         sfrRdHit,
  // program space
  input  wire        fetchReq,
  input  wire [15:0] fetchAddr,
  input  wire        constReq,
  input  wire        constIsWrite,
  input  wire [15:0] constAddr,
  input  wire        xmoveToFlash,
  output reg  [16:0] flashAddr,
  output reg         flashReserved,
  output reg         flashWrite,
  output reg         xramWrite,
  // internal data operation
  input  wire        dataReq,
  input  wire [2:0]  dataOp,
  input  wire [7:0]  dataAddr,
  input  wire        dataIndirect,
  input  wire        dataIsBit,
  input  wire [7:0]  dataWdata,
  input  wire [1:0]  regBankSel,
  output reg  [7:0]  dataRdata,
  output reg         sfrSelect,
  output reg  [7:0]  sfrDataAddr,
  output reg  [7:0]  stackPointer,
  output reg  [7:0]  codeBankSelReg
);
  // data operation codes
  localparam OP_READ = 3'd0;
  localparam OP_WRITE = 3'd1;
  localparam OP_PUSH = 3'd2;
  localparam OP_POP = 3'd3;
  localparam OP_SETSP = 3'd4;

  function [16:0] bankAddr;
    input [15:0] a;
    input [1:0]  bank;
    begin
      if (!a[`CBM_UPPER_BIT])
        bankAddr = {2'b00, a[14:0]};
      else
        bankAddr = {bank, a[14:0]};
    end
  endfunction

  wire [1:0] fetchBankField = codeBankSelReg[`CBM_FETCH_LSB +: 2];
  wire [1:0] constantBankField = codeBankSelReg[`CBM_CONST_LSB +: 2];
  // pc below 0x8000 means code runs from bank zero
  wire inBankZero = ~curPc[`CBM_UPPER_BIT] | (fetchBankField == 2'b00);

  // bank select register
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      codeBankSelReg <= `CBM_BANK_SEL_RESET;
    end else if (sfrWr && sfrAddr == `CBM_BANK_SEL_ADDR) begin
      codeBankSelReg[5:4] <= sfrWdata[5:4];
      if (inBankZero)
        codeBankSelReg[1:0] <= sfrWdata[1:0];
      codeBankSelReg[7:6] <= 2'b00;
      codeBankSelReg[3:2] <= 2'b00;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sfrRdata <= 8'h00;
      sfrRdHit <= 1'b0;
    end else begin
      sfrRdHit <= (sfrAddr == `CBM_BANK_SEL_ADDR);
      sfrRdata <= (sfrAddr == `CBM_BANK_SEL_ADDR) ?
                  (codeBankSelReg & `CBM_BANK_SEL_MASK) : 8'h00;
    end
  end

  // program space translation; fetch wins when both request
  reg [16:0] next_flashAddr;
  reg [15:0] selAddr;
  reg [1:0]  selBank;
  always @* begin
    selAddr = constAddr;
    selBank = constantBankField;
    if (fetchReq) begin
      selAddr = fetchAddr;
      selBank = fetchBankField;
    end
    next_flashAddr = bankAddr(selAddr, selBank);
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flashAddr <= 17'h00000;
      flashReserved <= 1'b0;
      flashWrite <= 1'b0;
      xramWrite <= 1'b0;
    end else begin
      flashAddr <= next_flashAddr;
      // top of bank three is unusable on the large part
      flashReserved <= BIG_FLASH && (fetchReq || constReq) &&
                       next_flashAddr[16:15] == 2'b11 &&
                       selAddr >= `CBM_RESERVED_BASE;
      // code reads always flash; external writes only when redirected
      flashWrite <= constReq && constIsWrite && xmoveToFlash &&
                    !fetchReq;
      xramWrite <= constReq && constIsWrite && !xmoveToFlash &&
                   !fetchReq;
    end
  end

  // data space decode
  wire [7:0] ramRdA;
  wire [7:0] ramRdB;
  reg        ramWe;
  reg  [7:0] ramWa;
  reg  [7:0] ramWd;
  reg  [7:0] rdAddr;
  reg  [7:0] ptrRegAddr;
  reg  [7:0] effAddr;
  reg  [7:0] next_sp;
  reg        toSfr;
  reg  [7:0] bitByte;

  always @* begin
    // pointer register zero or one of the active bank
    ptrRegAddr = {3'b000, regBankSel, 2'b00, dataAddr[0]};
    // bit form: byte 0x20+k, bit n
    bitByte = `CBM_BITREGION_BASE + {4'h0, dataAddr[6:3]};
    if (dataIndirect)
      effAddr = ramRdB;
    else if (dataIsBit)
      effAddr = bitByte;
    else
      effAddr = dataAddr;
    toSfr = !dataIndirect && !dataIsBit &&
            dataAddr > `CBM_DIRECT_TOP;
    next_sp = stackPointer;
    ramWe = 1'b0;
    ramWa = effAddr;
    ramWd = dataWdata;
    rdAddr = effAddr;
    if (dataReq) begin
      case (dataOp)
        OP_WRITE: begin
          ramWe = !toSfr;
          if (dataIsBit) begin
            ramWd = ramRdA;
            ramWd[dataAddr[2:0]] = dataWdata[0];
          end
        end
        OP_PUSH: begin
          // stack wraps in 256 bytes, always indirect-style
          ramWa = stackPointer + 8'h01;
          next_sp = stackPointer + 8'h01;
          ramWe = 1'b1;
        end
        OP_POP: begin
          rdAddr = stackPointer;
          next_sp = stackPointer - 8'h01;
        end
        OP_SETSP: next_sp = dataWdata;
        default: ;
      endcase
    end
  end

  cbm_ram #(
    .DEPTH (256),
    .AW    (8)
  ) u_ram (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wrEn     (ramWe),
    .wrAddr   (ramWa),
    .wrData   (ramWd),
    .rdAddrA  (rdAddr),
    .rdDataA  (ramRdA),
    .rdAddrB  (ptrRegAddr),
    .rdDataB  (ramRdB)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stackPointer <= `CBM_SP_RESET;
      dataRdata <= 8'h00;
      sfrSelect <= 1'b0;
      sfrDataAddr <= 8'h00;
    end else begin
      stackPointer <= next_sp;
      sfrSelect <= dataReq && toSfr &&
                   (dataOp == OP_READ || dataOp == OP_WRITE);
      sfrDataAddr <= dataAddr;
      if (dataReq && dataIsBit && dataOp == OP_READ)
        dataRdata <= {7'h00, ramRdA[dataAddr[2:0]]};
      else
        dataRdata <= ramRdA;
    end
  end
endmodule // cbm_mem_map

/* File: cbm_mem_map_sva.sv */
/* checker for the memory map block, bound to its top module ports.
   assumes one clock and an active-low asynchronous reset. */
module cbm_mem_map_chk (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        sfrWr,
  input wire logic [7:0]  sfrAddr,
  input wire logic [15:0] curPc,
  input wire logic        fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic        dataReq,
  input wire logic [2:0]  dataOp,
  input wire logic [7:0]  dataAddr,
  input wire logic        dataIndirect,
  input wire logic        dataIsBit,
  input wire logic [16:0] flashAddr,
  input wire logic        sfrSelect,
  input wire logic [7:0]  sfrDataAddr,
  input wire logic [7:0]  stackPointer,
  input wire logic [7:0]  codeBankSelReg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_push_bump: assert property (dataReq && dataOp == 3'h2 |=>
    stackPointer == $past(stackPointer) + 8'h01) else $error("push sp");
  chk_pop_drop: assert property (dataReq && dataOp == 3'h3 |=>
    stackPointer == $past(stackPointer) - 8'h01) else $error("pop sp");
  chk_resv_zero: assert property (codeBankSelReg[7:6] == 2'h0 &&
    codeBankSelReg[3:2] == 2'h0) else $error("reserved bits set");
  chk_direct_sfr: assert property (dataReq && !dataIndirect &&
    !dataIsBit && dataAddr[7] && dataOp < 3'h2 |=> sfrSelect &&
    sfrDataAddr == $past(dataAddr)) else $error("direct not sfr");
  chk_indir_ram: assert property (dataReq && dataIndirect |=>
    !sfrSelect) else $error("indirect hit sfr");
  chk_bank_zero: assert property (fetchReq && !fetchAddr[15] |=>
    flashAddr[16:15] == 2'h0) else $error("low fetch banked");
  chk_fetch_bank: assert property (fetchReq && fetchAddr[15] |=>
    flashAddr == {$past(codeBankSelReg[1:0]), $past(fetchAddr[14:0])})
    else $error("fetch bank wrong");
  chk_fetch_lock: assert property (sfrWr && sfrAddr == 8'hF5 &&
    curPc[15] && codeBankSelReg[1:0] != 2'h0 |=>
    $stable(codeBankSelReg[1:0])) else $error("fetch field changed");
endmodule // cbm_mem_map_chk
bind cbm_mem_map cbm_mem_map_chk u_chk (.core_clk, .nrst, .sfrWr, .sfrAddr,
  .curPc, .fetchReq, .fetchAddr, .dataReq, .dataOp, .dataAddr,
  .dataIndirect, .dataIsBit, .flashAddr, .sfrSelect, .sfrDataAddr,
  .stackPointer, .codeBankSelReg);

/* File: cbm_ram.v */
/*
  internal ram of the data space, flip-flop storage with one write port
  and two combinational read ports.
  assumes a single clock and asynchronous active-low reset.
*/
module cbm_ram #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          core_clk,
  input  wire          nrst,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [7:0]    wrData,
  input  wire [AW-1:0] rdAddrA,
  output wire [7:0]    rdDataA,
  input  wire [AW-1:0] rdAddrB,
  output wire [7:0]    rdDataB
);
  reg [7:0] mem [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_cell
      // index held at the port's width so the compare is exact
      localparam [AW-1:0] CELL_IDX = i;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
          mem[i] <= 8'h00;
        else if (wrEn && wrAddr == CELL_IDX)
          mem[i] <= wrData;
      end
    end
  endgenerate
  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];
endmodule // cbm_ram

/* File: tb_code_bank_data_memory_map.sv */
/* self-checking bench for the memory map block.
   assumes registered answers one edge after each request. */
module tb_code_bank_data_memory_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, nrst, sfrWr, fetchReq, constReq;
  logic        constIsWrite, xmoveToFlash, sfrRdHit, flashReserved;
  logic        flashWrite, xramWrite, sfrSelect, dataReq;
  logic        dataIndirect, dataIsBit;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, dataRdata, sfrDataAddr;
  logic [7:0]  stackPointer, codeBankSelReg, dataAddr, dataWdata;
  logic [15:0] curPc, fetchAddr, constAddr;
  logic [16:0] flashAddr;
  logic [2:0]  dataOp;
  logic [1:0]  regBankSel;
  int          errors, samples_checked;
  cbm_mem_map DUT (.core_clk, .nrst, .sfrWr, .sfrAddr, .sfrWdata, .curPc,
    .sfrRdata, .sfrRdHit, .fetchReq, .fetchAddr, .constReq, .constIsWrite,
    .constAddr, .xmoveToFlash, .flashAddr, .flashReserved, .flashWrite,
    .xramWrite, .dataReq, .dataOp, .dataAddr, .dataIndirect, .dataIsBit,
    .dataWdata, .regBankSel, .dataRdata, .sfrSelect, .sfrDataAddr,
    .stackPointer, .codeBankSelReg);
  cbm_core_model core (.core_clk, .dataReq, .dataOp, .dataAddr,
    .dataIndirect, .dataIsBit, .dataWdata, .regBankSel);
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic sfr_wr(input logic [7:0] d, input logic [15:0] pc);
    {sfrWr, sfrWdata, curPc} = {1'b1, d, pc};
    @(posedge core_clk);
    #1;
    sfrWr = 1'b0;
  endtask
  // k is {fetch, const, write, to flash}
  task automatic fl(input logic [3:0] k, input logic [15:0] a);
    {fetchReq, constReq, constIsWrite, xmoveToFlash, fetchAddr} = {k, a};
    constAddr = a;
    @(posedge core_clk);
    #1;
    {fetchReq, constReq, constIsWrite, xmoveToFlash} = 4'h0;
  endtask
  task automatic t_reset;
    chk(codeBankSelReg, 8'h11);
    chk(stackPointer, 8'h07);
    @(posedge core_clk);
    #1;
    chk({sfrRdHit, sfrRdata}, 9'h111);
  endtask
  task automatic t_stack;
    core.op(3'h2, 8'h00, 1'b0, 1'b0, 8'hA5, 2'h0);
    chk(stackPointer, 8'h08);
    core.op(3'h0, 8'h08, 1'b0, 1'b0, 8'h00, 2'h0);
    chk(dataRdata, 8'hA5);
    core.op(3'h2, 8'h00, 1'b0, 1'b0, 8'h3C, 2'h0);
    core.op(3'h3, 8'h00, 1'b0, 1'b0, 8'h00, 2'h0);
    chk({stackPointer, dataRdata}, 16'h083C);
    core.op(3'h4, 8'h00, 1'b0, 1'b0, 8'hFF, 2'h0);
    core.op(3'h2, 8'h00, 1'b0, 1'b0, 8'h5A, 2'h0);
    core.op(3'h0, 8'h00, 1'b0, 1'b0, 8'h00, 2'h0);
    chk({stackPointer, dataRdata}, 16'h005A);
  endtask
  task automatic t_data;
    core.op(3'h1, 8'h90, 1'b0, 1'b0, 8'h11, 2'h0);
    chk({sfrSelect, sfrDataAddr}, 9'h190);
    core.op(3'h1, 8'h10, 1'b0, 1'b0, 8'h90, 2'h0);
    core.op(3'h1, 8'h00, 1'b1, 1'b0, 8'hC3, 2'h2);
    core.op(3'h0, 8'h00, 1'b1, 1'b0, 8'h00, 2'h2);
    chk(dataRdata, 8'hC3);
    core.op(3'h0, 8'h00, 1'b1, 1'b0, 8'h00, 2'h0);
    chk(dataRdata, 8'h00);
    core.op(3'h1, 8'h22, 1'b0, 1'b0, 8'h08, 2'h0);
    core.op(3'h0, 8'h13, 1'b0, 1'b1, 8'h00, 2'h0);
    chk(dataRdata[0], 1'b1);
    core.op(3'h0, 8'h13, 1'b0, 1'b0, 8'h00, 2'h0);
    chk(dataRdata, 8'h00);
  endtask
  task automatic t_flash;
    fl(4'h8, 16'h1234);
    chk(flashAddr, 17'h01234);
    fl(4'h8, 16'h8001);
    chk(flashAddr, 17'h08001);
    sfr_wr(8'hEE, 16'h0100);
    chk(codeBankSelReg, 8'h22);
    fl(4'h8, 16'h8001);
    chk(flashAddr, 17'h10001);
    // the large part is built, so bank three at 0xFC00 must raise flashReserved
    sfr_wr(8'h33, 16'h8000);
    chk(codeBankSelReg, 8'h32);
    fl(4'h4, 16'hFC00);
    chk({flashReserved, flashAddr}, 18'h3FC00);
    fl(4'h6, 16'h9000);
    chk({flashWrite, xramWrite}, 2'h1);
    fl(4'h7, 16'h9000);
    chk({flashWrite, xramWrite}, 2'h2);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    {nrst, sfrWr, fetchReq, constReq, constIsWrite, xmoveToFlash} = 6'h0;
    {sfrWdata, curPc, fetchAddr, constAddr} = 56'h0;
    {errors, samples_checked, sfrAddr} = {32'h0, 32'h0, 8'hF5};
    repeat (8) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_reset;
    t_stack;
    t_data;
    t_flash;
    report_and_stop;
  end
endmodule // tb_code_bank_data_memory_map
